/* File: switch_host_bus_port_pkg.sv */
// Constants, field positions and state codes for the switch processor port.
// Assumes one 200 MHz core clock; every pin arrives asynchronously to it.
`default_nettype none

package switch_host_bus_port_pkg;

  // Data path and address widths
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 8;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int ACK_HIGH_NS = 10;
  // Longest time: rounds down, never below one cycle
  localparam int ACK_HIGH_CYCLES = (ACK_HIGH_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                   (ACK_HIGH_NS / CLK_PERIOD_NS);
  localparam int ACK_CNT_W = 2;
  localparam logic [ACK_CNT_W-1:0] ACK_CNT_ZERO = 2'h0;
  localparam logic [ACK_CNT_W-1:0] ACK_CNT_ONE = 2'h1;
  localparam logic [ACK_CNT_W-1:0] ACK_CNT_LOAD = ACK_CNT_W'(ACK_HIGH_CYCLES);

  // Positions in the synchronised pin vector
  localparam int PIN_CS_N = 0;
  localparam int PIN_STB = 1;
  localparam int PIN_RW = 2;
  localparam int PIN_ALE = 3;
  localparam int PIN_MUX = 4;
  localparam int PIN_SEP = 5;
  localparam int PIN_RST_N = 6;
  localparam int PIN_ADDR = 7;
  localparam int PIN_LOW = PIN_ADDR + ADDR_W;
  localparam int PIN_HIGH = PIN_LOW + BYTE_W;
  localparam int SYNC_W = PIN_HIGH + BYTE_W;
  // Reset image: chip select and device reset idle high, all else low
  localparam logic [SYNC_W-1:0] PIN_IDLE = 31'h0000_0041;

  // Address space split: top address bits pick the register space
  localparam int REG_SEL_MSB = 7;
  localparam int REG_SEL_LSB = 5;
  localparam logic [REG_SEL_MSB-REG_SEL_LSB:0] REG_SEL_CODE = 3'h0;

  typedef enum logic [1:0] {
    REGION_CTRL = 2'h0,
    REGION_DATA = 2'h1,
    REGION_CONN = 2'h2
  } region_e;

  // Gray path: idle -> access -> ack -> end -> idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01,
    ST_ACK = 2'b11,
    ST_END = 2'b10
  } port_state_e;

  // Target of an access from its address and the memory select bit
  function automatic region_e decode_region(input logic [ADDR_W-1:0] addr,
                                            input logic mem_sel);
    if (addr[REG_SEL_MSB:REG_SEL_LSB] == REG_SEL_CODE) begin
      return REGION_CTRL;
    end else if (mem_sel) begin
      return REGION_CONN;
    end else begin
      return REGION_DATA;
    end
  endfunction

endpackage

`default_nettype wire

/* File: pin_sync.sv */
// Three-stage synchroniser for a vector of asynchronous pins.
// Assumes each bit may change at any time; output moves when stages two and three agree.
`default_nettype none

module pin_sync
  import switch_host_bus_port_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] IDLE = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Pins and filtered result
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // Stages local to each bit so every flop has exactly one writer
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic out_reg;
      // First stage feeds only the second; the agree check uses two and three
      always_ff @(posedge core_clk) begin
        if (srst) begin
          s1_reg <= IDLE[i];
          s2_reg <= IDLE[i];
          s3_reg <= IDLE[i];
          out_reg <= IDLE[i];
        end else begin
          s1_reg <= pin_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            out_reg <= s3_reg;
          end
        end
      end
      assign pin_out[i] = out_reg;
    end
  endgenerate

endmodule

`default_nettype wire

/* File: ack_driver.sv */
// Open-drain style driver for the active-low transfer acknowledge pin.
// Assumes an external pull-up holds the pin high whenever it is released.
`default_nettype none

module ack_driver
  import switch_host_bus_port_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Control from the port sequencer
  input wire logic ack_assert,
  input wire logic cs_active,
  // Pin side: enable is low while driving
  output logic ack_n_out,
  output logic ack_oe_n
);

  logic assert_reg;
  logic [ACK_CNT_W-1:0] high_cnt_reg;
  logic [ACK_CNT_W-1:0] high_cnt_next;
  logic drive_low;
  logic drive_high;

  // Ack falling away starts the short high drive
  assign high_cnt_next = (assert_reg && !ack_assert) ? ACK_CNT_LOAD :
                         (high_cnt_reg != ACK_CNT_ZERO) ? high_cnt_reg - ACK_CNT_ONE :
                         ACK_CNT_ZERO;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      assert_reg <= 1'b0;
      high_cnt_reg <= ACK_CNT_ZERO;
    end else begin
      assert_reg <= ack_assert;
      high_cnt_reg <= high_cnt_next;
    end
  end

  // Strong high speeds the edge so a weak pull-up is enough
  assign drive_low = ack_assert;
  assign drive_high = !ack_assert && (high_cnt_reg != ACK_CNT_ZERO);
  assign ack_n_out = !drive_low;
  // Never drive without chip select
  assign ack_oe_n = !((drive_low || drive_high) && cs_active);

endmodule

`default_nettype wire

/* File: switch_host_bus_port.sv */
// Processor port of the time-slot switch: pin decode, address latch, access sequencer.
// Assumes the memories answer acc_req with acc_done and hold acc_rdata with it.
//
// Overview of operation
// - Mode pin high selects multiplexed, low non-multiplexed
// - Non-multiplexed address comes from dedicated lines
// - Multiplexed address comes from shared low pins
// - Sixteen-bit data: shared low byte, separate high
// - Multiplexed data strobe active high with chip select
// - Non-multiplexed data strobe active low with select
// - Separate-strobe style: drive bus while read low
// - Direction input picks read or write
// - Separate-strobe style: sample bus while write low
// - Chip select starts access; otherwise port ignored
// - Latch strobe used only in multiplexed mode
// - Assert acknowledge low when transfer completes
// - Drive acknowledge high briefly, then release it
// - Device reset clears state, floats outputs
// - Address plus memory select bit picks target
`default_nettype none

module switch_host_bus_port
  import switch_host_bus_port_pkg::*;
(
  // Core clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Port configuration pins
  input wire logic port_mux_select,
  input wire logic sep_strobe_style,
  input wire logic dev_reset_n,
  // Port control pins
  input wire logic chip_sel_n,
  input wire logic strobe_or_read_n,
  input wire logic rw_or_write_n,
  input wire logic addr_latch_strobe,
  input wire logic [ADDR_W-1:0] addr_lines,
  // Shared low byte pins
  input wire logic [BYTE_W-1:0] shared_low_byte_in,
  output logic [BYTE_W-1:0] shared_low_byte_out,
  output logic shared_low_byte_oe_n,
  // Upper byte pins
  input wire logic [BYTE_W-1:0] upper_byte_lines_in,
  output logic [BYTE_W-1:0] upper_byte_lines_out,
  output logic upper_byte_lines_oe_n,
  // Acknowledge pin
  output logic transfer_ack_n_out,
  output logic transfer_ack_n_oe_n,
  // Memory select from the control register
  input wire logic memory_select_bit,
  // Internal access request
  output logic acc_req,
  output logic acc_write,
  output logic [1:0] acc_region,
  output logic [ADDR_W-1:0] acc_addr,
  output logic [DATA_W-1:0] acc_wdata,
  // Internal access answer
  input wire logic acc_done,
  input wire logic [DATA_W-1:0] acc_rdata,
  // Device reset effects
  output logic clear_state,
  output logic serial_out_hiz
);

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic cs_act;
  logic stb_s;
  logic rw_s;
  logic ale_s;
  logic mux_mode;
  logic sep_style;
  logic dev_rst;
  logic [ADDR_W-1:0] addr_s;
  logic [BYTE_W-1:0] low_s;
  logic [BYTE_W-1:0] high_s;

  logic ds_high_act;
  logic ds_low_act;
  logic rd_act;
  logic wr_act;
  logic bus_active;
  logic is_read;
  logic ale_fall;
  logic [ADDR_W-1:0] addr_sel;
  logic drive_data;

  logic ale_prev_reg;
  logic [ADDR_W-1:0] addr_latch_reg;
  port_state_e state_reg;
  port_state_e state_next;
  logic req_reg;
  logic write_reg;
  region_e region_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic start;
  logic rdata_load;
  logic ack_req;

  // Every pin passes the three-stage filter
  assign pins_raw = {upper_byte_lines_in, shared_low_byte_in, addr_lines, dev_reset_n,
                     sep_strobe_style, port_mux_select, addr_latch_strobe, rw_or_write_n,
                     strobe_or_read_n, chip_sel_n};

  pin_sync #(
    .W(SYNC_W),
    .IDLE(PIN_IDLE)
  ) u_pin_sync (
    .core_clk(core_clk),
    .srst(srst),
    .pin_in(pins_raw),
    .pin_out(pins_s)
  );

  // Unpack filtered pins
  assign cs_act = !pins_s[PIN_CS_N];
  assign stb_s = pins_s[PIN_STB];
  assign rw_s = pins_s[PIN_RW];
  assign ale_s = pins_s[PIN_ALE];
  assign mux_mode = pins_s[PIN_MUX];
  assign sep_style = pins_s[PIN_SEP];
  assign dev_rst = srst || !pins_s[PIN_RST_N];
  assign addr_s = pins_s[PIN_LOW-1:PIN_ADDR];
  assign low_s = pins_s[PIN_HIGH-1:PIN_LOW];
  assign high_s = pins_s[SYNC_W-1:PIN_HIGH];

  // Strobe decode for the three bus styles
  assign ds_high_act = mux_mode && !sep_style && cs_act && stb_s;
  assign ds_low_act = !mux_mode && cs_act && !stb_s;
  assign rd_act = mux_mode && sep_style && cs_act && !stb_s;
  assign wr_act = mux_mode && sep_style && cs_act && !rw_s;
  // Nothing counts while chip select is high
  assign bus_active = ds_high_act || ds_low_act || rd_act || wr_act;
  // Direction: high means read in the strobe-plus-direction styles
  assign is_read = (mux_mode && sep_style) ? rd_act : rw_s;

  // Address latch on the falling edge, multiplexed mode only
  assign ale_fall = mux_mode && ale_prev_reg && !ale_s;

  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      ale_prev_reg <= 1'b0;
      addr_latch_reg <= '0;
    end else begin
      ale_prev_reg <= ale_s;
      if (ale_fall) begin
        addr_latch_reg <= low_s;
      end
    end
  end

  // Address source follows the mode pin
  assign addr_sel = mux_mode ? addr_latch_reg : addr_s;

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (bus_active) begin
          state_next = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (!bus_active) begin
          state_next = ST_END;
        end else if (acc_done) begin
          state_next = ST_ACK;
        end
      end
      ST_ACK: begin
        if (!bus_active) begin
          state_next = ST_END;
        end
      end
      ST_END: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  assign start = (state_reg == ST_IDLE) && bus_active;

  // State and request registers; device reset clears them
  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      state_reg <= ST_IDLE;
      req_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      req_reg <= start;
    end
  end

  // Direction captured once at the start; later pin noise cannot flip it
  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      write_reg <= 1'b0;
    end else if (start) begin
      write_reg <= !is_read;
    end
  end

  // Target region fixed for the whole access
  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      region_reg <= REGION_CTRL;
    end else if (start) begin
      region_reg <= decode_region(addr_sel, memory_select_bit);
    end
  end

  // Address held until the next request
  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      addr_reg <= '0;
    end else if (start) begin
      addr_reg <= addr_sel;
    end
  end

  // Write word from both byte lanes at once
  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      wdata_reg <= '0;
    end else if (start) begin
      wdata_reg <= {high_s, low_s};
    end
  end

  // Read data loads only on a completed read that is still strobed
  assign rdata_load = (state_reg == ST_ACCESS) && bus_active && acc_done && !write_reg;

  // Read data held until the next completed read
  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      rdata_reg <= '0;
    end else if (rdata_load) begin
      rdata_reg <= acc_rdata;
    end
  end

  // Internal request outputs
  assign acc_req = req_reg;
  assign acc_write = write_reg;
  assign acc_region = region_reg;
  assign acc_addr = addr_reg;
  assign acc_wdata = wdata_reg;

  // Drive data only on a read with chip select, never in device reset
  assign drive_data = bus_active && is_read && !dev_rst;
  assign shared_low_byte_out = rdata_reg[BYTE_W-1:0];
  assign upper_byte_lines_out = rdata_reg[DATA_W-1:BYTE_W];
  assign shared_low_byte_oe_n = !drive_data;
  assign upper_byte_lines_oe_n = !drive_data;

  // Acknowledge stays low only while the host still strobes
  assign ack_req = (state_reg == ST_ACK) && bus_active;

  // Acknowledge pin handling
  ack_driver u_ack_driver (
    .core_clk(core_clk),
    .srst(dev_rst),
    .ack_assert(ack_req),
    .cs_active(cs_act),
    .ack_n_out(transfer_ack_n_out),
    .ack_oe_n(transfer_ack_n_oe_n)
  );

  // Device reset effects seen by the rest of the switch
  assign clear_state = dev_rst;
  assign serial_out_hiz = dev_rst;

endmodule

`default_nettype wire

/* File: switch_host_bus_port_properties.sv */
// Checker on the processor port pins and the internal access strobe.
// Assumes pins pass a three-flop filter before the port acts on them.
`default_nettype none
module switch_host_bus_port_properties
  import switch_host_bus_port_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Pins
  input wire logic dev_reset_n,
  input wire logic chip_sel_n,
  input wire logic shared_low_byte_oe_n,
  input wire logic upper_byte_lines_oe_n,
  input wire logic transfer_ack_n_out,
  input wire logic transfer_ack_n_oe_n,
  input wire logic memory_select_bit,
  // Access side
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic [1:0] acc_region,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic acc_done
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Acknowledge wire states and any driver on
  wire ack_lo = !transfer_ack_n_oe_n && !transfer_ack_n_out;
  wire ack_hi = !transfer_ack_n_oe_n && transfer_ack_n_out;
  wire d_oe = !shared_low_byte_oe_n || !upper_byte_lines_oe_n;
  wire [1:0] exp_reg = (acc_addr[7:5] == 3'h0) ? 2'h0 : (memory_select_bit ? 2'h2 : 2'h1);

  a_idle_no_drive: assert property (chip_sel_n [*6] |-> !d_oe && transfer_ack_n_oe_n)
    else $error("port drives a pin without chip select");
  a_reset_floats: assert property (!dev_reset_n [*8] |-> !d_oe && transfer_ack_n_oe_n && !acc_req)
    else $error("port active during device reset");
  a_req_spaced: assert property (acc_req |=> !acc_req [*4])
    else $error("requests too close");
  a_ack_follows: assert property ($rose(ack_lo) |-> $past(acc_done))
    else $error("acknowledge without completed access");
  a_ack_high_brief: assert property (ack_hi [*2] |=> !ack_hi)
    else $error("acknowledge driven high too long");
  a_region_map: assert property (acc_req |-> acc_region == exp_reg)
    else $error("wrong access target");
  a_write_floats: assert property (acc_req && acc_write |-> !d_oe)
    else $error("data driven during write");
  a_read_drives: assert property (acc_req && !acc_write |-> !shared_low_byte_oe_n
    && !upper_byte_lines_oe_n)
    else $error("data not driven during read");

  // Main scenarios
  c_write: cover property (acc_req && acc_write);
  c_read: cover property (acc_req && !acc_write);
  c_ack: cover property ($rose(ack_lo));
endmodule

bind switch_host_bus_port switch_host_bus_port_properties u_props (.core_clk, .srst,
  .dev_reset_n, .chip_sel_n, .shared_low_byte_oe_n, .upper_byte_lines_oe_n,
  .transfer_ack_n_out, .transfer_ack_n_oe_n, .memory_select_bit, .acc_req, .acc_write,
  .acc_region, .acc_addr, .acc_done);
`default_nettype wire

/* File: host_cpu_model.sv */
// Processor model driving the port pins in all three bus styles.
// Assumes a pull-up on the acknowledge wire.
`default_nettype none
module host_cpu_model
  import switch_host_bus_port_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Device side of shared wires
  input wire logic [BYTE_W-1:0] shared_low_byte_out,
  input wire logic shared_low_byte_oe_n,
  input wire logic [BYTE_W-1:0] upper_byte_lines_out,
  input wire logic upper_byte_lines_oe_n,
  input wire logic transfer_ack_n_out,
  input wire logic transfer_ack_n_oe_n,
  // Processor pins
  output logic port_mux_select,
  output logic sep_strobe_style,
  output logic chip_sel_n,
  output logic strobe_or_read_n,
  output logic rw_or_write_n,
  output logic addr_latch_strobe,
  output logic [ADDR_W-1:0] addr_lines,
  output logic [BYTE_W-1:0] shared_low_byte_in,
  output logic [BYTE_W-1:0] upper_byte_lines_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b0;
  logic [DATA_W-1:0] dq = 16'h0000;
  // Released wires show the inverse, so stale data cannot pass
  assign shared_low_byte_in = !shared_low_byte_oe_n ? shared_low_byte_out :
                              drv ? dq[7:0] : ~dq[7:0];
  assign upper_byte_lines_in = !upper_byte_lines_oe_n ? upper_byte_lines_out :
                               drv ? dq[15:8] : ~dq[15:8];
  wire ack_n = transfer_ack_n_oe_n | transfer_ack_n_out;
  initial begin
    {port_mux_select, sep_strobe_style, addr_latch_strobe} = 3'h0;
    {chip_sel_n, strobe_or_read_n, rw_or_write_n} = 3'h7;
    addr_lines = 8'h00;
  end
  // Style change, only between accesses
  task automatic cfg(input logic mux, input logic sep);
    @(posedge core_clk);
    port_mux_select <= mux;
    sep_strobe_style <= sep;
    strobe_or_read_n <= !(mux && !sep);
  endtask
  // One access; sel low leaves chip select off
  task automatic xfer(input logic wr, sel, input logic [7:0] a,
                      inout logic [15:0] d, output logic ok);
    int n;
    n = 0;
    @(posedge core_clk);
    addr_lines <= port_mux_select ? ~a : a;
    if (port_mux_select) begin
      dq <= {8'h00, a};
      drv <= 1'b1;
      addr_latch_strobe <= 1'b1;
      repeat (5) @(posedge core_clk);
      addr_latch_strobe <= 1'b0;
      repeat (5) @(posedge core_clk);
    end
    dq <= d;
    drv <= wr;
    chip_sel_n <= !sel;
    rw_or_write_n <= !wr;
    @(posedge core_clk);
    strobe_or_read_n <= port_mux_select && (!sep_strobe_style || wr);
    while (ack_n && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    ok = !ack_n;
    d = {upper_byte_lines_in, shared_low_byte_in};
    strobe_or_read_n <= !(port_mux_select && !sep_strobe_style);
    rw_or_write_n <= 1'b1;
    drv <= 1'b0;
    repeat (3) @(posedge core_clk);
    chip_sel_n <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// Bench: processor model on the pins, memory model on the access side.
// Assumes the port answers within forty cycles of the strobe.
`default_nettype none
module tb;
  import switch_host_bus_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic dev_reset_n = 1'b1;
  logic memory_select_bit = 1'b0;
  logic acc_done = 1'b0;
  logic [15:0] acc_rdata = 16'h0000;
  wire logic port_mux_select, sep_strobe_style, chip_sel_n, strobe_or_read_n;
  wire logic rw_or_write_n, addr_latch_strobe, shared_low_byte_oe_n;
  wire logic upper_byte_lines_oe_n, transfer_ack_n_out, transfer_ack_n_oe_n;
  wire logic acc_req, acc_write, clear_state, serial_out_hiz;
  wire logic [7:0] addr_lines, shared_low_byte_in, shared_low_byte_out, acc_addr;
  wire logic [7:0] upper_byte_lines_in, upper_byte_lines_out;
  wire logic [1:0] acc_region;
  wire logic [15:0] acc_wdata;
  int err_total = 0;
  int samples_checked = 0;
  int n_req = 0;
  int wait_n = 0;
  int mem[256];
  logic [15:0] ex_a, ex_w, ex_d;

  switch_host_bus_port u_switch_host_bus_port (.core_clk, .srst, .port_mux_select,
    .sep_strobe_style, .dev_reset_n, .chip_sel_n, .strobe_or_read_n, .rw_or_write_n,
    .addr_latch_strobe, .addr_lines, .shared_low_byte_in, .shared_low_byte_out,
    .shared_low_byte_oe_n, .upper_byte_lines_in, .upper_byte_lines_out,
    .upper_byte_lines_oe_n, .transfer_ack_n_out, .transfer_ack_n_oe_n, .memory_select_bit,
    .acc_req, .acc_write, .acc_region, .acc_addr, .acc_wdata, .acc_done, .acc_rdata,
    .clear_state, .serial_out_hiz);
  host_cpu_model cpu (.core_clk, .shared_low_byte_out, .shared_low_byte_oe_n,
    .upper_byte_lines_out, .upper_byte_lines_oe_n, .transfer_ack_n_out,
    .transfer_ack_n_oe_n, .port_mux_select, .sep_strobe_style, .chip_sel_n,
    .strobe_or_read_n, .rw_or_write_n, .addr_latch_strobe, .addr_lines,
    .shared_low_byte_in, .upper_byte_lines_in);

  initial forever #2.5 core_clk = ~core_clk;

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, s, e);
    end
  endtask

  task automatic report_and_stop();
    if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Memory model: random answer delay, data from the bench array
  always @(posedge core_clk) begin
    acc_done <= (wait_n == 1);
    if (wait_n > 0) wait_n <= wait_n - 1;
    if (acc_req) begin
      n_req++;
      chk(16'(acc_addr), ex_a);
      chk(16'(acc_write), ex_w);
      if (acc_write) chk(acc_wdata, ex_d);
      acc_rdata <= mem[acc_addr][15:0];
      wait_n <= 1 + int'($urandom % 4);
    end
  end

  // One transfer checked against the bench memory
  task automatic op(input logic wr, sel, input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic ok;
    int n0;
    n0 = n_req;
    ex_a = 16'(a);
    ex_w = 16'(wr);
    ex_d = d;
    q = d;
    cpu.xfer(wr, sel, a, q, ok);
    chk(16'(ok), 16'(sel));
    chk(16'(n_req - n0), 16'(sel));
    if (ok !== sel) report_and_stop();
    if (!wr && sel) chk(q, mem[a][15:0]);
    if (wr && sel) mem[a] = int'(d);
  endtask

  initial begin
    logic [7:0] a;
    logic [15:0] d;
    void'($urandom(32'hb3f4));
    foreach (mem[i]) mem[i] = int'($urandom);
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    // Each style with both memory select values
    for (int s = 0; s < 6; s++) begin
      cpu.cfg(s % 3 != 0, s % 3 == 2);
      memory_select_bit <= s[0];
      repeat (8) @(posedge core_clk);
      for (int k = 0; k < 4; k++) begin
        a = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
        d = 16'($urandom);
        op(1'b1, 1'b1, a, d);
        op(1'b0, 1'b1, a, d);
      end
      op(1'b1, 1'b0, 8'h5a, 16'h1234);
      op(1'b0, 1'b0, 8'h5a, 16'h1234);
    end
    // Device reset held 100 ns: state clears, pins float
    dev_reset_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk(16'({clear_state, serial_out_hiz, shared_low_byte_oe_n, upper_byte_lines_oe_n,
      transfer_ack_n_oe_n}), 16'h001f);
    dev_reset_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    op(1'b0, 1'b1, a, d);
    report_and_stop();
  end
endmodule
`default_nettype wire
